//--- spl_limiters.sv
`timescale 1ns/100ps
`include "spl_cfg.svh"
module spl_limiters
  import spl_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      resetn,
  input  wire logic      regWrite,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  output logic [7:0]     regRdata,
  input  wire logic      activePath,
  input  wire logic      inValid,
  output logic           inReady,
  input  wire spl_pair_s inData,
  output logic           outValid,
  input  wire logic      outReady,
  output spl_pair_s      outData,
  input  wire logic      ampValid,
  input  wire spl_amp_s  ampMon,
  output spl_spk_s       spkLeft,
  output spl_spk_s       spkRight
);

  spl_state_s         q;
  spl_state_s         next_q;
  spl_exc_e           mode;
  logic               dyn;
  logic [15:0]        kLow, kHigh, excThr, pwrThr, relStep;
  logic [31:0]        sq;
  logic [19:0]        est;
  logic [3:0]         weight;
  logic [7:0]         clipLim, clipSum;
  logic [4:0]         base;
  logic signed [15:0] cf [5];
  logic signed [15:0] x, y, loN, hiN, lowOut;
  logic signed [35:0] acc, v, d;
  logic               push, pop;
  spl_pair_s          filt;

  function automatic logic signed [15:0] sat16(input logic signed [35:0] a);
    if (a > 36'sh7fff)
      return 16'sh7fff;
    if (a < -36'sh8000)
      return -16'sh8000;
    return a[15:0];
  endfunction : sat16

  // Only the listed corner pairs are legal; anything else bypasses the filter
  function automatic spl_exc_e decode(input logic [2:0] u, input logic [1:0] l);
    unique case (l)
      2'h0: return (u == 3'h0) ? EXC_OFF : ((u <= 3'h4) ? EXC_FIX_PRESET : EXC_OFF);
      2'h1: return (u == 3'h1) ? EXC_DYN_PRESET : EXC_OFF;
      2'h2: return (u == 3'h2 || u == 3'h3) ? EXC_DYN_PRESET : EXC_OFF;
      2'h3: return (u == 3'h0) ? EXC_FIX_PROG : ((u <= 3'h4) ? EXC_DYN_PROG : EXC_OFF);
    endcase
  endfunction : decode

  // Thermal model step; a disabled or reserved constant tracks power at once
  function automatic logic [31:0] ema(input logic [31:0] e, input logic [15:0] p, input logic [3:0] code);
    logic [191:0]       tab;
    logic signed [50:0] step;
    tab  = `SPL_TC_ALPHA;
    step = ($signed({1'b0, p, 16'h0000}) - $signed({1'b0, e})) * $signed({1'b0, tab[code*16 +: 16]});
    if (code == 4'h0 || code > `SPL_TC_LAST)
      return {p, 16'h0000};
    return e + 32'(step >>> `SPL_ALPHA_FRAC);
  endfunction : ema

  // Configuration decode from the stored registers
  assign mode    = decode(q.exc[`SPL_UCF], q.exc[`SPL_LCF]);
  assign dyn     = (mode == EXC_DYN_PRESET) || (mode == EXC_DYN_PROG);
  assign kLow    = (q.exc[`SPL_LCF] == 2'h1) ? `SPL_K_200 : `SPL_K_400;
  assign kHigh   = (q.exc[`SPL_UCF] == 3'h1) ? `SPL_K_400 : (q.exc[`SPL_UCF] == 3'h2) ? `SPL_K_600 :
                   (q.exc[`SPL_UCF] == 3'h3) ? `SPL_K_800 : `SPL_K_1K;
  // Tables are cut to one slice on purpose; code 0 sits in the lowest slice
  assign excThr  = 16'(`SPL_EXC_TAB >> (q.excThr[`SPL_EXC_THR] * 16));
  assign pwrThr  = 16'({`SPL_PWR_TAB1, `SPL_PWR_TAB0} >> (q.pwr[`SPL_PTH] * 16));
  // Codes 100, 101 and the reserved 11x all give the shortest release
  assign relStep = 16'(`SPL_REL_STEP) >> ((q.rel[`SPL_REL] > `SPL_REL_MAXSH) ? `SPL_REL_MAXSH : q.rel[`SPL_REL]);
  assign weight  = 4'(`SPL_WEIGHT_TAB >> (q.pwr[`SPL_PWK] * 4));
  assign clipLim = 8'(`SPL_CLIP_TAB >> (q.thd[`SPL_THD] * 8));
  assign base    = activePath ? `SPL_COEF_SET : 5'h00;
  assign push    = inValid && q.inReady;
  assign pop     = q.outValid && outReady;
  // Power of the speaker output, full scale level squared
  assign sq      = ampMon.level * ampMon.level;
  assign est     = 20'((q.eCoil[31:16] * weight + q.eMag[31:16] * (`SPL_WEIGHT_ALL - weight)) >> 3);
  // Count saturates, so a fully clipped window cannot wrap back to zero
  assign clipSum = (q.clipCnt == `SPL_CLIP_MAX) ? `SPL_CLIP_MAX : q.clipCnt + {7'h00, ampMon.clip};

  // Whole next state in one process
  always_comb
  begin
    next_q = q;
    x      = 16'sh0000;
    y      = 16'sh0000;
    loN    = 16'sh0000;
    hiN    = 16'sh0000;
    lowOut = 16'sh0000;
    acc    = 36'sh0;
    v      = 36'sh0;
    d      = 36'sh0;
    filt   = inData;
    for (int i = 0; i < 5; i++)
      cf[i] = {q.coef[5'(base + 5'(2 * i))], q.coef[5'(base + 5'(2 * i + 1))]};

    // Register writes from the control interface
    if (regWrite)
    begin
      if (regAddr >= `SPL_COEF_FIRST && regAddr <= `SPL_COEF_LAST)
        next_q.coef[5'(regAddr - `SPL_COEF_FIRST)] = regWdata;
      else
        unique case (regAddr)
          `SPL_REG_VOL_L:   next_q.volL = regWdata;
          `SPL_REG_VOL_R:   next_q.volR = regWdata;
          `SPL_REG_EXC:     next_q.exc = regWdata;
          `SPL_REG_EXC_THR: next_q.excThr = regWdata;
          `SPL_REG_REL:     next_q.rel = regWdata;
          `SPL_REG_PWR:     next_q.pwr = regWdata;
          `SPL_REG_PWR_TC:  next_q.pwrTc = regWdata;
          `SPL_REG_THD:     next_q.thd = regWdata;
          default:          next_q.rdata = q.rdata;
        endcase
    end

    // Read data follows the address one cycle later; unmapped reads zero
    next_q.rdata = `SPL_REG_RST;
    if (regAddr >= `SPL_COEF_FIRST && regAddr <= `SPL_COEF_LAST)
      next_q.rdata = q.coef[5'(regAddr - `SPL_COEF_FIRST)];
    else
      unique case (regAddr)
        `SPL_REG_VOL_L:   next_q.rdata = q.volL;
        `SPL_REG_VOL_R:   next_q.rdata = q.volR;
        `SPL_REG_EXC:     next_q.rdata = q.exc;
        `SPL_REG_EXC_THR: next_q.rdata = q.excThr;
        `SPL_REG_REL:     next_q.rdata = q.rel;
        `SPL_REG_PWR:     next_q.rdata = q.pwr;
        `SPL_REG_PWR_TC:  next_q.rdata = q.pwrTc;
        `SPL_REG_THD:     next_q.rdata = q.thd;
        default:          next_q.rdata = `SPL_REG_RST;
      endcase

    // Excursion filter per channel, run only when a sample enters the buffer
    for (int c = 0; c < 2; c++)
    begin
      x   = (c == 0) ? inData.left : inData.right;
      // Denominator terms are stored negated, so they are added
      acc = cf[0] * x + cf[1] * q.ch[c].x1 + cf[2] * q.ch[c].x2
          + cf[3] * q.ch[c].y1 + cf[4] * q.ch[c].y2;
      y   = sat16(acc >>> `SPL_BQ_FRAC);
      v   = q.ch[c].lo + x - q.ch[c].x1;
      loN = sat16(v - ((v * $signed({1'b0, kLow})) >>> `SPL_K_FRAC));
      v   = q.ch[c].hi + x - q.ch[c].x1;
      hiN = sat16(v - ((v * $signed({1'b0, kHigh})) >>> `SPL_K_FRAC));
      // Biquad is the low side in programmable modes
      lowOut = (mode == EXC_FIX_PROG || mode == EXC_DYN_PROG) ? y : loN;
      // Crossfade by slide position keeps the corner change smooth
      d = hiN - lowOut;
      if (mode != EXC_OFF)
        x = sat16(lowOut + ((d * $signed({1'b0, q.pos})) >>> `SPL_POS_SHIFT));
      if (c == 0)
        filt.left = x;
      else
        filt.right = x;
      if (push)
      begin
        next_q.ch[c].x2 = q.ch[c].x1;
        next_q.ch[c].x1 = (c == 0) ? inData.left : inData.right;
        next_q.ch[c].y2 = q.ch[c].y1;
        next_q.ch[c].y1 = y;
        next_q.ch[c].lo = loN;
        next_q.ch[c].hi = hiN;
      end
    end

    // Corner slide driven by the measured speaker output
    if (mode == EXC_FIX_PRESET)
      next_q.pos = `SPL_POS_FULL;
    else if (!dyn)
      next_q.pos = 9'h000;
    else if (ampValid)
    begin
      if (ampMon.level > excThr)
      begin
        next_q.relCnt = 16'h0000;
        if (q.pos < `SPL_POS_FULL)
          next_q.pos = q.pos + 9'h001;
      end
      else if (q.relCnt + 16'h0001 >= relStep)
      begin
        next_q.relCnt = 16'h0000;
        if (q.pos != 9'h000)
          next_q.pos = q.pos - 9'h001;
      end
      else
        next_q.relCnt = q.relCnt + 16'h0001;
    end

    // Two-constant thermal model; magnet stage runs sixty times slower
    if (ampValid)
    begin
      next_q.eCoil  = ema(q.eCoil, sq[31:16], q.pwrTc[`SPL_TC1]);
      next_q.magDiv = (q.magDiv == `SPL_MAG_DIV) ? 6'h00 : q.magDiv + 6'h01;
      if (q.magDiv == `SPL_MAG_DIV)
        next_q.eMag = ema(q.eMag, sq[31:16], q.pwrTc[`SPL_TC2]);
      // Mute holds only while the estimate stays above the limit
      next_q.powerMute = (pwrThr != 16'h0000) && (est > pwrThr);
    end
    if (pwrThr == 16'h0000)
      next_q.powerMute = 1'b0;

    // Clip ratio over a 256-sample window steps the gain reduction
    if (ampValid)
    begin
      next_q.winCnt  = q.winCnt + 8'h01;
      next_q.clipCnt = clipSum;
      if (q.winCnt == `SPL_WIN_LAST)
      begin
        next_q.clipCnt = 8'h00;
        if (clipLim != 8'h00 && clipSum > clipLim)
          next_q.att = (q.att < `SPL_ATT_MAX) ? q.att + 5'h01 : q.att;
        else if (q.att != 5'h00)
          next_q.att = q.att - 5'h01;
      end
    end
    if (clipLim == 8'h00)
      next_q.att = 5'h00;

    // Power and clip limiters act only on the analog speaker volume
    next_q.spkL.mute = q.volL[`SPL_MUTE_BIT] || q.powerMute;
    next_q.spkR.mute = q.volR[`SPL_MUTE_BIT] || q.powerMute;
    next_q.spkL.vol  = (q.volL[`SPL_VOL] > q.att) ? q.volL[`SPL_VOL] - q.att : 5'h00;
    next_q.spkR.vol  = (q.volR[`SPL_VOL] > q.att) ? q.volR[`SPL_VOL] - q.att : 5'h00;

    // Two-entry buffer; ready is registered from the next fill level
    if (pop)
    begin
      next_q.fifo[0] = q.fifo[1];
      next_q.cnt     = q.cnt - 2'h1;
    end
    if (push)
    begin
      next_q.fifo[next_q.cnt[0]] = filt;
      next_q.cnt                 = next_q.cnt + 2'h1;
    end
    next_q.outValid = (next_q.cnt != 2'h0);
    next_q.inReady  = (next_q.cnt != 2'h2);
  end

  // State register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      q <= '0;
    else
      q <= next_q;
  end

  assign regRdata = q.rdata;
  assign inReady  = q.inReady;
  assign outValid = q.outValid;
  assign outData  = q.fifo[0];
  assign spkLeft  = q.spkL;
  assign spkRight = q.spkR;

  // Checks share the one clock; reset aborts any attempt in flight
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_power_mute_set: assert property (ampValid && pwrThr != 16'h0000 && est > pwrThr |=> q.powerMute)
    else $error("power mute not raised");
  a_power_off_code: assert property (q.pwr[`SPL_PTH] == 4'h0 |=> !q.powerMute)
    else $error("power mute while disabled");
  a_power_mute_lift: assert property (ampValid && q.powerMute && est <= pwrThr |=> !q.powerMute)
    else $error("power mute not released");
  a_mute_to_pin: assert property (q.powerMute |=> q.spkL.mute && q.spkR.mute)
    else $error("speaker mute not driven");
  a_fixed_preset_pos: assert property (mode == EXC_FIX_PRESET |=> q.pos == `SPL_POS_FULL)
    else $error("preset corner not held high");
  a_fixed_prog_pos: assert property (mode == EXC_FIX_PROG |=> q.pos == 9'h000)
    else $error("programmable corner slid");
  a_slide_rise: assert property (dyn && ampValid && ampMon.level > excThr && q.pos < `SPL_POS_FULL
                                 |=> q.pos == $past(q.pos) + 9'h001)
    else $error("corner did not rise");
  a_slide_smooth: assert property (dyn ##1 dyn |-> q.pos <= $past(q.pos) + 9'h001 && q.pos + 9'h001 >= $past(q.pos))
    else $error("corner stepped");
  a_thd_off_code: assert property (q.thd[`SPL_THD] == 4'h0 |=> q.att == 5'h00 ##1 q.spkL.vol == $past(q.volL[`SPL_VOL]))
    else $error("gain reduced while disabled");
  a_thd_reduce: assert property (ampValid && q.winCnt == `SPL_WIN_LAST && clipLim != 8'h00 && clipSum > clipLim
                                 && q.att < `SPL_ATT_MAX |=> q.att == $past(q.att) + 5'h01)
    else $error("gain not reduced");
  a_buffer_full: assert property (q.cnt == 2'h2 |-> !inReady)
    else $error("ready while buffer full");
  a_buffer_empty: assert property (q.cnt == 2'h0 |-> !outValid)
    else $error("valid while buffer empty");
  // Release side of the slide, volume path and bypass
  a_slide_release: assert property (dyn && ampValid && ampMon.level <= excThr && q.relCnt + 16'h0001 >= relStep
                                    && q.pos != 9'h000 |=> q.pos == $past(q.pos) - 9'h001)
    else $error("corner did not fall");
  a_unmute_pin: assert property (!q.powerMute && !q.volL[`SPL_MUTE_BIT] |=> !q.spkL.mute)
    else $error("speaker mute stuck");
  a_gain_floor: assert property (q.att == 5'h00 |=> q.spkL.vol == $past(q.volL[`SPL_VOL]))
    else $error("left gain reduced without cause");
  a_gain_right: assert property (q.att == 5'h00 |=> q.spkR.vol == $past(q.volR[`SPL_VOL]))
    else $error("right gain reduced without cause");
  a_bypass_pass: assert property (mode == EXC_OFF && push && q.cnt == 2'h0 |=> outData == $past(inData))
    else $error("bypass altered the sample");

  c_power_mute: cover property ($rose(q.powerMute));
  c_slide_full: cover property (dyn && q.pos == `SPL_POS_FULL);
  c_thd_reduce: cover property (q.att != 5'h00);
  c_buffer_full: cover property (q.cnt == 2'h2 ##1 pop);
  // Programmable dynamic mode with a sample passing
  c_dyn_prog: cover property (mode == EXC_DYN_PROG && push);

endmodule : spl_limiters

//--- spl_cfg.svh
`ifndef SPL_CFG_SVH
`define SPL_CFG_SVH
// Register offsets
`define SPL_REG_VOL_L   8'h3d
`define SPL_REG_VOL_R   8'h3e
`define SPL_REG_EXC     8'h41
`define SPL_REG_EXC_THR 8'h42
`define SPL_REG_REL     8'h43
`define SPL_REG_PWR     8'h44
`define SPL_REG_PWR_TC  8'h45
`define SPL_REG_THD     8'h46
`define SPL_COEF_FIRST  8'hb4
`define SPL_COEF_LAST   8'hc7
`define SPL_COEF_SET    5'h0a
`define SPL_REG_RST     8'h00
// Field positions
`define SPL_MUTE_BIT    7
`define SPL_VOL         4:0
`define SPL_UCF         6:4
`define SPL_LCF         1:0
`define SPL_EXC_THR     2:0
`define SPL_REL         6:4
`define SPL_PTH         7:4
`define SPL_PWK         2:0
`define SPL_TC2         7:4
`define SPL_TC1         3:0
`define SPL_THD         7:4
// Corner coefficients, Q15 of 2*pi*f/fs at 48 kHz
`define SPL_K_200       16'h035a
`define SPL_K_400       16'h06b4
`define SPL_K_600       16'h0a0d
`define SPL_K_800       16'h0d67
`define SPL_K_1K        16'h10c1
`define SPL_POS_FULL    9'h100
`define SPL_POS_SHIFT   8
`define SPL_BQ_FRAC     14
`define SPL_K_FRAC      15
`define SPL_ALPHA_FRAC  24
// Release timing: longest release in ms, sample rate, steps of the slide
`define SPL_REL_MS      4000
`define SPL_FS_HZ       48000
`define SPL_REL_STEP    (`SPL_REL_MS * `SPL_FS_HZ / 1000 / 256)
`define SPL_REL_MAXSH   3'h4
// Code tables, code 0 in the low slice
`define SPL_EXC_TAB {16'he666, 16'hc5d2, 16'h9746, 16'h6c74, 16'h5263, 16'h3c82, 16'h210c, 16'h0fd3}
`define SPL_PWR_TAB1 {16'hf3d0, 16'hd4a8, 16'hc1b2, 16'h8773, 16'h6186, 16'h4104, 16'h2f68, 16'h2492}
`define SPL_PWR_TAB0 {16'h1dcc, 16'h1861, 16'h119b, 16'h0ee6, 16'h0c30, 16'h0820, 16'h06c5, 16'h0000}
`define SPL_TC_ALPHA {16'h0027, 16'h0034, 16'h0046, 16'h005d, 16'h007c, 16'h00a6, 16'h00dd, 16'h0126, \
                      16'h0189, 16'h020a, 16'h02bb, 16'h0000}
`define SPL_TC_LAST     4'hb
`define SPL_MAG_DIV     6'h3b
`define SPL_WEIGHT_TAB  {4'h3, 4'h2, 4'h1, 4'h8, 4'h7, 4'h6, 4'h5, 4'h4}
`define SPL_WEIGHT_ALL  4'h8
`define SPL_CLIP_TAB {8'h3d, 8'h38, 8'h36, 8'h33, 8'h2e, 8'h29, 8'h24, 8'h1f, \
                      8'h1a, 8'h14, 8'h0f, 8'h0a, 8'h05, 8'h03, 8'h02, 8'h00}
`define SPL_WIN_LAST    8'hff
`define SPL_CLIP_MAX    8'hff
`define SPL_ATT_MAX     5'h0f
`endif

//--- spl_pkg.sv
package spl_pkg;
  typedef enum logic [2:0] {EXC_OFF, EXC_FIX_PRESET, EXC_FIX_PROG, EXC_DYN_PRESET, EXC_DYN_PROG} spl_exc_e;
  typedef struct packed {
    logic signed [15:0] left;
    logic signed [15:0] right;
  } spl_pair_s;
  typedef struct packed {
    logic [15:0] level;
    logic        clip;
  } spl_amp_s;
  typedef struct packed {
    logic signed [15:0] x1;
    logic signed [15:0] x2;
    logic signed [15:0] y1;
    logic signed [15:0] y2;
    logic signed [15:0] lo;
    logic signed [15:0] hi;
  } spl_chan_s;
  typedef struct packed {
    logic       mute;
    logic [4:0] vol;
  } spl_spk_s;
  typedef struct packed {
    logic [7:0]       volL, volR, exc, excThr, rel, pwr, pwrTc, thd;
    logic [19:0][7:0] coef;
    spl_chan_s [1:0]  ch;
    logic [8:0]       pos;
    logic [15:0]      relCnt;
    logic [31:0]      eCoil, eMag;
    logic [5:0]       magDiv;
    logic             powerMute;
    logic [7:0]       clipCnt, winCnt;
    logic [4:0]       att;
    spl_pair_s [1:0]  fifo;
    logic [1:0]       cnt;
    logic             outValid, inReady;
    spl_spk_s         spkL, spkR;
    logic [7:0]       rdata;
  } spl_state_s;
endpackage : spl_pkg

//--- spl_limiters_bench.sv
`timescale 1ns/100ps
module spl_limiters_bench import spl_pkg::*;;
  logic       clk;
  logic       resetn;
  logic       regWrite;
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic       activePath;
  logic       inValid;
  logic       inReady;
  spl_pair_s  inData;
  logic       outValid;
  logic       outReady;
  spl_pair_s  outData;
  logic       ampValid;
  spl_amp_s   ampMon;
  spl_spk_s   spkLeft;
  spl_spk_s   spkRight;
  spl_pair_s  got;
  int         mismatches;
  int         totalChecks;
  logic [7:0] regList [10] = '{8'h3d, 8'h3e, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'hb4, 8'hc7};

  spl_limiters dut (.clk(clk), .resetn(resetn), .regWrite(regWrite), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .activePath(activePath), .inValid(inValid),
    .inReady(inReady), .inData(inData), .outValid(outValid), .outReady(outReady),
    .outData(outData), .ampValid(ampValid), .ampMon(ampMon), .spkLeft(spkLeft), .spkRight(spkRight));

  // Free-running 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // One place ends the run, whatever the path to it
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    totalChecks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  // A wait that runs dry is a failure, not a hang
  task automatic hang(input string msg);
    mismatches++;
    $display("BAD %0t %s: no answer", $time, msg);
    give_verdict();
  endtask : hang

  // Write strobe lasts one edge; next call starts on a later edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr

  // Read data is registered, so it lags the address by one edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string msg);
    @(posedge clk);
    regAddr <= a;
    repeat (2) @(posedge clk);
    chk(32'(regRdata), 32'(exp), msg);
  endtask : rd

  // Valid stays up until each word is taken
  task automatic send(input spl_pair_s w [2], input int num);
    int n;
    inValid <= 1'b1;
    for (int i = 0; i < num; i++)
    begin
      inData <= w[i];
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (inReady !== 1'b1 && n < 50);
      if (n >= 50)
        hang("input refused");
    end
    inValid <= 1'b0;
  endtask : send

  task automatic pop(output spl_pair_s d);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!(outValid === 1'b1 && outReady === 1'b1) && n < 50);
    if (n >= 50)
      hang("no output");
    d = outData;
  endtask : pop

  task automatic filt(input spl_pair_s x, output spl_pair_s y);
    send('{x, x}, 1);
    pop(y);
  endtask : filt

  // Mid-run reset clears every register and all filter state
  task automatic do_reset();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : do_reset

  // Back-to-back measurements, then time for the volume to follow
  task automatic amp(input logic [15:0] lvl, input logic clp, input int n);
    ampMon   <= '{level: lvl, clip: clp};
    ampValid <= 1'b1;
    repeat (n) @(posedge clk);
    ampValid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : amp

  // Main sequence
  initial
  begin
    resetn = 1'b0; regWrite = 1'b0; regAddr = 8'h00; regWdata = 8'h00; activePath = 1'b0;
    inValid = 1'b0; inData = '0; outReady = 1'b1; ampValid = 1'b0; ampMon = '0;
    mismatches = 0;
    totalChecks = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    chk(32'(inReady), 32'h1, "ready after reset");
    // Registers come up clear, hold what is written, unmapped reads zero
    foreach (regList[i])
      rd(regList[i], 8'h00, "reset value");
    foreach (regList[i])
      wr(regList[i], 8'(8'h11 * (i + 1)));
    foreach (regList[i])
      rd(regList[i], 8'(8'h11 * (i + 1)), "read back");
    foreach (regList[i])
      wr(regList[i], 8'h00);
    wr(8'h40, 8'hff);
    rd(8'h40, 8'h00, "unmapped place");
    rd(8'hc8, 8'h00, "past coefficient range");
    // Stalled sink: two words held in order, no third taken
    outReady <= 1'b0;
    send('{'{16'h0111, 16'h0222}, '{16'h0333, 16'h0444}}, 2);
    repeat (4) @(posedge clk);
    chk(32'(inReady), 32'h0, "full buffer still ready");
    chk(32'(outData), 32'h01110222, "head lost while stalled");
    outReady <= 1'b1;
    pop(got);
    chk(32'(got), 32'h01110222, "first word");
    pop(got);
    chk(32'(got), 32'h03330444, "second word");
    @(posedge clk);
    chk(32'(outValid), 32'h0, "buffer not empty");
    // Biquad alone, one coefficient set per path
    wr(8'hb4, 8'h40);
    wr(8'hbe, 8'h20);
    wr(8'h41, 8'h03);
    filt('{16'h1000, 16'hf000}, got);
    chk(32'(got), 32'h1000f000, "first path biquad");
    activePath <= 1'b1;
    filt('{16'h1000, 16'hf000}, got);
    chk(32'(got), 32'h0800f800, "second path biquad");
    activePath <= 1'b0;
    // A pair outside the valid list leaves the signal alone
    wr(8'h41, 8'h01);
    filt('{16'h1234, 16'h5678}, got);
    chk(32'(got), 32'h12345678, "invalid corner pair");
    // Fixed upper corner removes a steady level whatever its size
    wr(8'h41, 8'h40);
    repeat (60) filt('{16'h4000, 16'h4000}, got);
    chk(32'(got.left < 16'sh0200 && got.left > -16'sh0200), 32'h1, "steady level kept");
    // Power limiter judges the output level against the top threshold
    wr(8'h41, 8'h00);
    wr(8'h3d, 8'h15);
    wr(8'h3e, 8'h15);
    wr(8'h44, 8'hf4);
    amp(16'hc000, 1'b0, 4);
    chk(32'(spkLeft), 32'h15, "muted below threshold");
    amp(16'hffff, 1'b0, 4);
    chk(32'(spkLeft), 32'h35, "left not muted");
    chk(32'(spkRight), 32'h35, "right not muted");
    amp(16'h0000, 1'b0, 4);
    chk(32'(spkLeft), 32'h15, "mute did not lift");
    wr(8'h44, 8'h04);
    amp(16'hffff, 1'b0, 4);
    chk(32'(spkLeft), 32'h15, "disabled limiter muted");
    // Host mute bit reaches the analog setting of one side only
    wr(8'h3d, 8'h95);
    repeat (3) @(posedge clk);
    chk(32'(spkLeft), 32'h35, "left mute bit");
    chk(32'(spkRight), 32'h15, "right disturbed");
    wr(8'h3d, 8'h15);
    // Heavy clipping above the lowest limit pulls the gain down
    wr(8'h46, 8'h10);
    amp(16'h0000, 1'b1, 520);
    chk(32'(spkLeft.vol < 5'h15), 32'h1, "gain not reduced");
    chk(32'(spkRight.vol < 5'h15), 32'h1, "right gain not reduced");
    wr(8'h46, 8'h00);
    amp(16'h0000, 1'b1, 4);
    chk(32'(spkLeft), 32'h15, "disable kept attenuation");
    amp(16'h0000, 1'b1, 300);
    chk(32'(spkLeft), 32'h15, "disabled limiter acted");
    // Programmable dynamic: biquad as low side, stored negated a1 fed back
    do_reset();
    wr(8'hb4, 8'h40);
    wr(8'hba, 8'h20);
    wr(8'h41, 8'h13);
    filt('{16'h4000, 16'h4000}, got);
    chk(32'(got), 32'h40004000, "biquad low side");
    filt('{16'h0000, 16'h0000}, got);
    chk(32'(got), 32'h20002000, "denominator feedback");
    // Preset dynamic: a fresh step meets the low corner, after loud output the high one
    do_reset();
    wr(8'h41, 8'h11);
    filt('{16'h4000, 16'h4000}, got);
    chk(32'(got), 32'h3e533e53, "low corner step");
    do_reset();
    wr(8'h41, 8'h11);
    amp(16'hffff, 1'b0, 260);
    filt('{16'h4000, 16'h4000}, got);
    chk(32'(got), 32'h3ca63ca6, "high corner step");
    amp(16'h0000, 1'b0, 760);
    chk(32'(spkLeft), 32'h00, "quiet output disturbed volume");
    give_verdict();
  end
endmodule : spl_limiters_bench
